// *** sebs_drive_model.sv ***
// Model of the controller terminals and the motor behind the drive
`timescale 1ns/100ps
`default_nettype none
module sebs_drive_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               son_req,
    input  wire logic [3:1]         aux_req,
    input  wire logic [3:0]         pol,
    input  wire logic signed [15:0] run_speed,
    input  wire logic [7:0]         decel,
    input  wire logic               excite,
    input  wire logic               brake_release,
    output logic [3:0]              di_term,
    output logic signed [15:0]      speed_meas
);
    logic signed [15:0] spd_q;
    logic signed [15:0] spd_d;
    logic signed [15:0] step;

    // Wire level is the requested state seen through the polarity mask
    assign di_term = {aux_req, son_req} ^ pol;
    assign step = {8'h00, decel};
    assign speed_meas = spd_q;

    // Motor follows drive when excited, coasts down, stops on the brake
    always_comb begin
        spd_d = spd_q;
        if (excite) begin
            spd_d = run_speed;
        end else if (!brake_release) begin
            spd_d = 16'sh0000;
        end else if (spd_q > step) begin
            spd_d = spd_q - step;
        end else if (spd_q < -step) begin
            spd_d = spd_q + step;
        end else begin
            spd_d = 16'sh0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_q <= 16'sh0000;
        end else begin
            spd_q <= spd_d;
        end
    end
endmodule
`default_nettype wire

// *** sebs_pkg.sv ***
// Constants, register map and types of the servo enable/brake sequencer
// Contract
// - Speed command is low-pass filtered, cutoff 1..1000 Hz, default 300.
// - A brake sequence starts when servo-on goes inactive or on an alarm.
// - At standstill brake drops first, excitation after still delay x10ms.
// - In motion excitation goes first, brake drops after wait time x10ms.
// - In motion brake engages at wait expiry or at the brake action speed.
// - Torque mode clamps the speed reference to the limit, default 3000.
// - Force-enable 0 takes enable from servo-on; 1 holds the servo enabled.
// - After servo-on drops, current flows on for the servo-off delay.
// - A 4-bit polarity mask, default 0000, bit n serves terminal n+1.
// - Polarity bit 0 means active high, 1 means active low.
// - Torque mode is control mode 2 with internal torque select 1.
`default_nettype none
package sebs_pkg;
    // Time base
    localparam int CLK_HZ       = 125_000_000;
    localparam int TICK_NS      = 100_000;
    localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_NS / 1000;
    localparam int TICKS_10MS   = 100;
    // Speed at or below this counts as standstill
    localparam int STILL_RPM    = 10;
    // Filter gain per Hz: 2*pi*0.1ms in Q16
    localparam int ALPHA_PER_HZ = 41;
    // Register offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_CUTOFF = 8'h04;
    localparam logic [7:0] A_STILL  = 8'h08;
    localparam logic [7:0] A_MOVE   = 8'h0C;
    localparam logic [7:0] A_BSPD   = 8'h10;
    localparam logic [7:0] A_TQLIM  = 8'h14;
    localparam logic [7:0] A_SOFF   = 8'h18;
    localparam logic [7:0] A_STAT   = 8'h1C;
    // CTRL field positions
    localparam int F_FORCE = 0;
    localparam int F_POL   = 4;
    localparam int F_MODE  = 8;
    localparam int F_ITQ   = 12;
    // Values after reset
    localparam logic [9:0]  RST_CUTOFF = 10'h12C;
    localparam logic [7:0]  RST_STILL  = 8'h00;
    localparam logic [7:0]  RST_MOVE   = 8'h32;
    localparam logic [11:0] RST_BSPD   = 12'h064;
    localparam logic [12:0] RST_TQLIM  = 13'h0BB8;
    localparam logic [14:0] RST_SOFF   = 15'h0000;
    localparam logic [3:0]  RST_POL    = 4'h0;
    localparam logic [3:0]  TORQUE_MODE_VAL = 4'h2;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_ON    = 3'h1,
        ST_SOFF  = 3'h2,
        ST_STILL = 3'h3,
        ST_MOVE  = 3'h4
    } sebs_state_e;
endpackage
`default_nettype wire

// *** sebs_tb_top.sv ***
// Self-checking testbench of the servo enable and brake sequencer
`timescale 1ns/100ps
`default_nettype none
module sebs_tb_top;
    // Short tick keeps the 10 ms delays near 400 cycles
    localparam int TC = 4;
    logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, ALARM = 1'b0, servo_on_input = 1'b0;
    logic PREADY, PSLVERR, TORQUE_MODE, EXCITE, BRAKE_RELEASE;
    logic [7:0] PADDR = 8'h00, decel = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [3:0] DI_TERM, DI_ACTIVE, pol = 4'h0;
    logic [3:1] aux = 3'h0;
    logic signed [15:0] SPEED_MEAS, SPEED_REF;
    logic signed [15:0] SPEED_CMD_IN = 16'sh0000, run_spd = 16'sh0000;
    int fail_count = 0, comparisons = 0;

    always #4 CLK = ~CLK;

    sebs_top #(.TICK_CYCLES(TC)) dut (
        .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .DI_TERM(DI_TERM),
        .ALARM(ALARM), .SPEED_MEAS(SPEED_MEAS), .SPEED_CMD_IN(SPEED_CMD_IN),
        .SPEED_REF(SPEED_REF), .DI_ACTIVE(DI_ACTIVE),
        .TORQUE_MODE(TORQUE_MODE), .EXCITE(EXCITE),
        .BRAKE_RELEASE(BRAKE_RELEASE));

    sebs_drive_model model (
        .clk(CLK), .rst(RST), .son_req(servo_on_input), .aux_req(aux), .pol(pol),
        .run_speed(run_spd), .decel(decel), .excite(EXCITE),
        .brake_release(BRAKE_RELEASE), .di_term(DI_TERM),
        .speed_meas(SPEED_MEAS));

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; request held until PREADY is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            check("pready", 32'h0, 32'h1);
            test_done();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // Edges until EXCITE (sel 0) or BRAKE_RELEASE reaches a level
    task automatic wait_out(input int sel, input logic lvl, output int n);
        logic v;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            v = (sel == 0) ? EXCITE : BRAKE_RELEASE;
        end while (v !== lvl && n < 3000);
        if (n >= 3000) begin
            check("output wait", 32'h0, 32'h1);
            test_done();
        end
    endtask

    task automatic t_regs();
        logic [7:0] ad [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                               8'h18, 8'h1C, 8'h20};
        logic [31:0] ex [9] = '{32'h0, 32'h12C, 32'h0, 32'h32, 32'h64,
                                32'hBB8, 32'h0, 32'h0, 32'h0};
        logic [31:0] r;
        logic e;
        wr(8'h20, 32'hFFFF_FFFF);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, ad[i], 32'h0, r, e);
            check("reg value", r, ex[i]);
            check("reg error", {31'h0, e}, {31'h0, i == 8});
        end
        $display("Finished regs");
    endtask

    task automatic t_polarity();
        pol <= 4'hA;
        aux <= 3'b101;
        wr(8'h00, 32'h0000_00A0);
        repeat (8) @(posedge CLK);
        check("di active", {28'h0, DI_ACTIVE}, 32'hA);
        aux <= 3'b010;
        repeat (8) @(posedge CLK);
        check("di active", {28'h0, DI_ACTIVE}, 32'h4);
        pol <= 4'h0;
        aux <= 3'h0;
        wr(8'h00, 32'h0);
        $display("Finished polarity");
    endtask

    task automatic t_force();
        logic [31:0] r;
        logic e;
        int n;
        wr(8'h00, 32'h1);
        wait_out(0, 1'b1, n);
        apb(1'b0, 8'h1C, 32'h0, r, e);
        check("status forced", r, 32'h31);
        wr(8'h00, 32'h0);
        wait_out(0, 1'b0, n);
        check("force off", {31'h0, n <= 10}, 32'h1);
        $display("Finished force");
    endtask

    task automatic t_still();
        int n;
        wr(8'h08, 32'h1);
        wr(8'h18, 32'h5);
        servo_on_input <= 1'b1;
        wait_out(0, 1'b1, n);
        servo_on_input <= 1'b0;
        wait_out(1, 1'b0, n);
        check("soff delay", {31'h0, n >= 20 && n <= 32}, 32'h1);
        check("still excite", {31'h0, EXCITE}, 32'h1);
        wait_out(0, 1'b0, n);
        check("still delay", {31'h0, n >= 396 && n <= 408}, 32'h1);
        wr(8'h08, 32'h0);
        wr(8'h18, 32'h0);
        $display("Finished standstill");
    endtask

    // Alarm while turning; brake waits for speed or the wait time
    task automatic t_move(input logic signed [15:0] spd,
                          input logic [7:0] dec, input int lo,
                          input int hi);
        int n;
        run_spd <= spd;
        decel <= dec;
        servo_on_input <= 1'b1;
        wait_out(0, 1'b1, n);
        repeat (4) @(posedge CLK);
        ALARM <= 1'b1;
        servo_on_input <= 1'b0;
        wait_out(0, 1'b0, n);
        check("move excite", {31'h0, n <= 4}, 32'h1);
        check("move brake", {31'h0, BRAKE_RELEASE}, 32'h1);
        wait_out(1, 1'b0, n);
        check("move wait", {31'h0, n >= lo && n <= hi}, 32'h1);
        ALARM <= 1'b0;
        repeat (10) @(posedge CLK);
        $display("Finished moving");
    endtask

    task automatic t_speed();
        wr(8'h04, 32'h1);
        SPEED_CMD_IN <= 16'sd1000;
        repeat (400) @(posedge CLK);
        check("slow filter", {31'h0, SPEED_REF > 16'sd30
                              && SPEED_REF < 16'sd100}, 32'h1);
        wr(8'h04, 32'h3E8);
        repeat (400) @(posedge CLK);
        check("fast filter", {31'h0, SPEED_REF > 16'sd900}, 32'h1);
        wr(8'h14, 32'hC8);
        wr(8'h00, 32'h1200);
        repeat (40) @(posedge CLK);
        check("torque mode", {31'h0, TORQUE_MODE}, 32'h1);
        check("clamp", {16'h0, SPEED_REF}, 32'h00C8);
        SPEED_CMD_IN <= -16'sd1000;
        repeat (800) @(posedge CLK);
        check("clamp neg", {16'h0, SPEED_REF}, 32'hFF38);
        wr(8'h00, 32'h0200);
        repeat (4) @(posedge CLK);
        check("mode only", {31'h0, TORQUE_MODE}, 32'h0);
        $display("Finished speed");
    endtask

    // Reset in mid-run while excited; cutoff register returns to its default
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        int n;
        servo_on_input <= 1'b1;
        wait_out(0, 1'b1, n);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        check("reset outputs", {30'h0, EXCITE, BRAKE_RELEASE}, 32'h0);
        RST <= 1'b0;
        servo_on_input <= 1'b0;
        apb(1'b0, 8'h04, 32'h0, r, e);
        check("reset cutoff", r, 32'h12C);
        $display("Finished reset");
    endtask

    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        t_regs();
        t_polarity();
        t_force();
        t_still();
        t_move(-16'sd2000, 8'd10, 186, 198);
        wr(8'h0C, 32'h1);
        t_move(16'sd2000, 8'd0, 396, 408);
        t_speed();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire

// *** sebs_top.sv ***
// Servo enable and brake sequencer with APB parameter registers
`timescale 1ns/100ps
`default_nettype none
module sebs_top #(
    parameter int TICK_CYCLES = sebs_pkg::TICK_CYCLES
) (
    input  wire logic               CLK,
    input  wire logic               RST,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic [3:0]         DI_TERM,
    input  wire logic               ALARM,
    input  wire logic signed [15:0] SPEED_MEAS,
    input  wire logic signed [15:0] SPEED_CMD_IN,
    output logic signed [15:0]      SPEED_REF,
    output logic [3:0]              DI_ACTIVE,
    output logic                    TORQUE_MODE,
    output logic                    EXCITE,
    output logic                    BRAKE_RELEASE
);
    // Magnitude of a signed speed
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction
    // Delay in 10 ms units to ticks
    function automatic logic [15:0] to_ticks(input logic [7:0] d);
        to_ticks = 16'(d * sebs_pkg::TICKS_10MS);
    endfunction

    // Registers
    logic        force_q, force_d;
    logic [3:0]  pol_q, pol_d, mode_q, mode_d;
    logic        itq_q, itq_d;
    logic [9:0]  cut_q, cut_d;
    logic [7:0]  still_q, still_d, move_q, move_d;
    logic [11:0] bspd_q, bspd_d;
    logic [12:0] tqlim_q, tqlim_d;
    logic [14:0] soff_q, soff_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic        hit;
    logic [31:0] rval;
    sebs_pkg::sebs_state_e st_q, st_d;

    // APB decode; one wait state so read data comes from a flop
    always_comb begin
        force_d = force_q;
        pol_d = pol_q;
        mode_d = mode_q;
        itq_d = itq_q;
        cut_d = cut_q;
        still_d = still_q;
        move_d = move_q;
        bspd_d = bspd_q;
        tqlim_d = tqlim_q;
        soff_d = soff_q;
        hit = 1'b1;
        rval = 32'h0;
        case (PADDR)
            sebs_pkg::A_CTRL: begin
                rval[sebs_pkg::F_FORCE] = force_q;
                rval[sebs_pkg::F_POL +: 4] = pol_q;
                rval[sebs_pkg::F_MODE +: 4] = mode_q;
                rval[sebs_pkg::F_ITQ] = itq_q;
            end
            sebs_pkg::A_CUTOFF: rval[9:0] = cut_q;
            sebs_pkg::A_STILL:  rval[7:0] = still_q;
            sebs_pkg::A_MOVE:   rval[7:0] = move_q;
            sebs_pkg::A_BSPD:   rval[11:0] = bspd_q;
            sebs_pkg::A_TQLIM:  rval[12:0] = tqlim_q;
            sebs_pkg::A_SOFF:   rval[14:0] = soff_q;
            sebs_pkg::A_STAT: begin
                rval[2:0] = st_q;
                rval[4] = EXCITE;
                rval[5] = BRAKE_RELEASE;
                rval[6] = TORQUE_MODE;
                rval[11:8] = DI_ACTIVE;
            end
            default: hit = 1'b0;
        endcase
        pready_d = PSEL & PENABLE & ~PREADY;
        prdata_d = (pready_d & ~PWRITE) ? rval : 32'h0;
        pslverr_d = pready_d & ~hit;
        // Write lands at the edge where the master sees PREADY high
        if (PSEL && PENABLE && PREADY && PWRITE && hit) begin
            case (PADDR)
                sebs_pkg::A_CTRL: begin
                    force_d = PWDATA[sebs_pkg::F_FORCE];
                    pol_d = PWDATA[sebs_pkg::F_POL +: 4];
                    mode_d = PWDATA[sebs_pkg::F_MODE +: 4];
                    itq_d = PWDATA[sebs_pkg::F_ITQ];
                end
                sebs_pkg::A_CUTOFF: cut_d = PWDATA[9:0];
                sebs_pkg::A_STILL:  still_d = PWDATA[7:0];
                sebs_pkg::A_MOVE:   move_d = PWDATA[7:0];
                sebs_pkg::A_BSPD:   bspd_d = PWDATA[11:0];
                sebs_pkg::A_TQLIM:  tqlim_d = PWDATA[12:0];
                sebs_pkg::A_SOFF:   soff_d = PWDATA[14:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            force_q <= 1'b0;
            pol_q <= sebs_pkg::RST_POL;
            mode_q <= 4'h0;
            itq_q <= 1'b0;
            cut_q <= sebs_pkg::RST_CUTOFF;
            still_q <= sebs_pkg::RST_STILL;
            move_q <= sebs_pkg::RST_MOVE;
            bspd_q <= sebs_pkg::RST_BSPD;
            tqlim_q <= sebs_pkg::RST_TQLIM;
            soff_q <= sebs_pkg::RST_SOFF;
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            force_q <= force_d;
            pol_q <= pol_d;
            mode_q <= mode_d;
            itq_q <= itq_d;
            cut_q <= cut_d;
            still_q <= still_d;
            move_q <= move_d;
            bspd_q <= bspd_d;
            tqlim_q <= tqlim_d;
            soff_q <= soff_d;
            PRDATA <= prdata_d;
            PREADY <= pready_d;
            PSLVERR <= pslverr_d;
        end
    end

    // Input terminals: three flops, change taken when last two agree
    logic [3:0] s1_q, s2_q, s3_q, di_q, di_d, act_d;
    always_comb begin
        di_d = di_q;
        for (int i = 0; i < 4; i++) begin
            if (s2_q[i] == s3_q[i]) di_d[i] = s3_q[i];
        end
        act_d = di_q ^ pol_q;
    end

    // 0.1 ms tick prescaler
    logic [15:0] pre_q, pre_d;
    logic        tick;
    always_comb begin
        tick = (pre_q == 16'(TICK_CYCLES - 1));
        pre_d = tick ? 16'h0 : pre_q + 16'h1;
    end

    // First-order low-pass, Q16 state, updated each tick
    logic signed [31:0] y_q, y_d;
    logic signed [16:0] diff, alpha;
    logic signed [33:0] prod;
    logic signed [15:0] yo, lim, ref_d;
    logic               tqm_d;
    always_comb begin
        alpha = 17'(((cut_q == 10'h0) ? 10'h1 : cut_q)
                * sebs_pkg::ALPHA_PER_HZ);
        diff = 17'(SPEED_CMD_IN) - 17'(signed'(y_q[31:16])); // Keep sign
        prod = diff * alpha;
        y_d = tick ? y_q + prod[31:0] : y_q;
        yo = y_q[31:16];
        lim = 16'(tqlim_q);
        tqm_d = (mode_q == sebs_pkg::TORQUE_MODE_VAL) && itq_q;
        ref_d = yo;
        if (TORQUE_MODE) begin
            if (yo > lim) ref_d = lim;
            else if (yo < -lim) ref_d = -lim;
        end
    end

    // Sequencer; enable from servo-on unless forced
    logic        servo_on_input, son_q, alm_q, en, moving_q, moving_d;
    logic [15:0] cnt_q, cnt_d, tgt;
    logic        exc_d, brk_d, slow;
    always_comb begin
        servo_on_input = DI_ACTIVE[0];
        en = force_q | servo_on_input;
        slow = mag(SPEED_MEAS) <= 16'(bspd_q);
        st_d = st_q;
        moving_d = moving_q;
        cnt_d = tick ? cnt_q + 16'h1 : cnt_q;
        tgt = 16'h0;
        case (st_q)
            sebs_pkg::ST_SOFF:  tgt = 16'(soff_q);
            sebs_pkg::ST_STILL: tgt = to_ticks(still_q);
            sebs_pkg::ST_MOVE:  tgt = to_ticks(move_q);
            default:  tgt = 16'h0;
        endcase
        case (st_q)
            sebs_pkg::ST_OFF: begin
                if (en && !ALARM) st_d = sebs_pkg::ST_ON;
            end
            sebs_pkg::ST_ON: begin
                // Speed latched at the trigger picks the sequence
                moving_d = mag(SPEED_MEAS) > 16'(sebs_pkg::STILL_RPM);
                if (ALARM && !alm_q) begin
                    st_d = moving_d ? sebs_pkg::ST_MOVE
                                    : sebs_pkg::ST_STILL;
                end else if (!en && son_q) begin
                    st_d = sebs_pkg::ST_SOFF;
                end
            end
            sebs_pkg::ST_SOFF: begin
                if (ALARM) begin
                    st_d = moving_q ? sebs_pkg::ST_MOVE
                                    : sebs_pkg::ST_STILL;
                end else if (en) begin
                    st_d = sebs_pkg::ST_ON;
                end else if (cnt_q >= tgt) begin
                    st_d = moving_q ? sebs_pkg::ST_MOVE
                                    : sebs_pkg::ST_STILL;
                end
            end
            sebs_pkg::ST_STILL: begin
                if (cnt_q >= tgt) st_d = sebs_pkg::ST_OFF;
            end
            sebs_pkg::ST_MOVE: begin
                if (cnt_q >= tgt || slow) st_d = sebs_pkg::ST_OFF;
            end
            default: st_d = sebs_pkg::ST_OFF;
        endcase
        if (st_d != st_q) cnt_d = 16'h0;
        // Outputs follow the next state so they change with it
        exc_d = (st_d == sebs_pkg::ST_ON) || (st_d == sebs_pkg::ST_SOFF)
             || (st_d == sebs_pkg::ST_STILL);
        brk_d = (st_d == sebs_pkg::ST_ON)
             || (st_d == sebs_pkg::ST_SOFF) || (st_d == sebs_pkg::ST_MOVE);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            di_q <= 4'h0;
            DI_ACTIVE <= 4'h0;
            pre_q <= 16'h0;
            y_q <= 32'h0;
            SPEED_REF <= 16'h0;
            TORQUE_MODE <= 1'b0;
            st_q <= sebs_pkg::ST_OFF;
            moving_q <= 1'b0;
            cnt_q <= 16'h0;
            son_q <= 1'b0;
            alm_q <= 1'b0;
            EXCITE <= 1'b0;
            BRAKE_RELEASE <= 1'b0;
        end else begin
            s1_q <= DI_TERM;
            s2_q <= s1_q;
            s3_q <= s2_q;
            di_q <= di_d;
            DI_ACTIVE <= act_d;
            pre_q <= pre_d;
            y_q <= y_d;
            SPEED_REF <= ref_d;
            TORQUE_MODE <= tqm_d;
            st_q <= st_d;
            moving_q <= moving_d;
            cnt_q <= cnt_d;
            son_q <= en;
            alm_q <= ALARM;
            EXCITE <= exc_d;
            BRAKE_RELEASE <= brk_d;
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_pol;
        DI_ACTIVE == ($past(di_q) ^ $past(pol_q));
    endproperty
    a_pol: assert property (p_pol)
        else $error("input polarity wrong");
    property p_force;
        (force_q && st_q == sebs_pkg::ST_OFF && !ALARM)
            |=> st_q == sebs_pkg::ST_ON && EXCITE && BRAKE_RELEASE;
    endproperty
    a_force: assert property (p_force)
        else $error("forced enable not taken");
    property p_trig;
        (st_q == sebs_pkg::ST_ON && !en && son_q)
            |=> st_q != sebs_pkg::ST_ON;
    endproperty
    a_trig: assert property (p_trig)
        else $error("servo-off did not start sequence");
    property p_still;
        st_q == sebs_pkg::ST_STILL |-> !BRAKE_RELEASE && EXCITE;
    endproperty
    a_still: assert property (p_still)
        else $error("standstill order wrong");
    property p_move;
        st_q == sebs_pkg::ST_MOVE |-> !EXCITE && BRAKE_RELEASE;
    endproperty
    a_move: assert property (p_move)
        else $error("motion order wrong");
    property p_slow;
        (st_q == sebs_pkg::ST_MOVE && slow)
            |=> st_q == sebs_pkg::ST_OFF ##0 !BRAKE_RELEASE;
    endproperty
    a_slow: assert property (p_slow)
        else $error("brake not engaged at action speed");
    property p_clamp;
        (TORQUE_MODE && yo > lim) |=> SPEED_REF == $past(lim);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("torque mode speed not clamped");
    property p_soff;
        (st_q == sebs_pkg::ST_SOFF && cnt_q < tgt && !ALARM && !en)
            |=> EXCITE;
    endproperty
    a_soff: assert property (p_soff)
        else $error("current cut before servo-off delay");
    property p_filt;
        (tick && SPEED_CMD_IN == yo && y_q[15:0] == 16'h0) |=> $stable(y_q);
    endproperty
    a_filt: assert property (p_filt)
        else $error("filter moved at rest");

    c_still: cover property (st_q == sebs_pkg::ST_STILL
                             ##1 st_q == sebs_pkg::ST_OFF);
    c_move: cover property (st_q == sebs_pkg::ST_MOVE && slow);
    c_alarm: cover property (st_q == sebs_pkg::ST_ON && ALARM);
    c_clamp: cover property (TORQUE_MODE && yo > lim);
endmodule
`default_nettype wire
